// file: dbio_cfg.svh
// Offsets, field positions, reset values and timing counts for the baseband I/O and status registers.
// Assumes a 32-bit APB slave with byte addresses and a 125 MHz pclk.
`ifndef DBIO_CFG_SVH
`define DBIO_CFG_SVH

`define DBIO_ADDR_W 8
`define DBIO_ADDR_RX_STATUS 8'h20
`define DBIO_ADDR_POLARITY 8'h24
`define DBIO_ADDR_RSSI 8'h28
`define DBIO_ADDR_CAL_POS 8'h2C
`define DBIO_ADDR_CAL_NEG 8'h30
`define DBIO_ADDR_SPREAD_HI 8'h34
`define DBIO_ADDR_SPREAD_LO 8'h38
`define DBIO_ADDR_CODE_LEN 8'h50
`define DBIO_ADDR_SF_CMP_A 8'hA8
`define DBIO_ADDR_SF_CMP_B 8'hAC

`define DBIO_POL_RXCLK 7
`define DBIO_POL_MDRDY 6
`define DBIO_POL_CCA 5
`define DBIO_POL_ENERGY 4
`define DBIO_POL_CARRIER 3
`define DBIO_POL_TXRDY 2
`define DBIO_POL_TXEN 1
`define DBIO_POL_TX_CLOCK 0

`define DBIO_STAT_SF_MISMATCH 7
`define DBIO_STAT_SFD_TIMEOUT 6
`define DBIO_STAT_MOD_QPSK 5

`define DBIO_RST_POLARITY 8'h00
`define DBIO_RST_CAL_POS 8'h01
`define DBIO_RST_CAL_NEG 8'hFF
`define DBIO_RST_CAL_LEVEL 8'h80
`define DBIO_RST_SPREAD_HI 8'h05
`define DBIO_RST_SPREAD_LO 8'hB8
`define DBIO_RST_SF_CMP 8'h0A

`define DBIO_CLK_PS 8000
`define DBIO_LINK_HALF_PS 62500
`define DBIO_LINK_HALF_CYCLES (`DBIO_LINK_HALF_PS / `DBIO_CLK_PS)
`define DBIO_SFD_TIMEOUT_CYCLES 4096

`endif

// file: dbio_pkg.sv
// Types for the baseband I/O and status register block.
// Assumes dbio_cfg.svh is compiled alongside.
package dbio_pkg;

  typedef enum logic [1:0] {
    DBIO_LEN_11 = 2'b00,
    DBIO_LEN_13 = 2'b01,
    DBIO_LEN_15 = 2'b10,
    DBIO_LEN_16 = 2'b11
  } dbio_code_len_t;

  typedef struct packed {
    logic [7:0] polarity;
    logic [7:0] cal_pos;
    logic [7:0] cal_neg;
    logic [7:0] cal_level;
    logic [7:0] spread_hi;
    logic [7:0] spread_lo;
    dbio_code_len_t code_len;
    logic [7:0] sf_cmp_a;
    logic [7:0] sf_cmp_b;
    logic [5:0] rssi;
    logic sf_mismatch;
    logic sfd_timeout;
    logic mod_qpsk;
    logic [15:0] sfd_timer;
    logic sfd_searching;
    logic acq_restart;
    logic [7:0] link_div;
    logic link_clk;
    logic [3:0] chip_idx;
    logic chip;
    logic txen_sync1;
    logic txen_sync2;
    logic tx_enable;
    logic rx_clk_out;
    logic tx_clk_out;
    logic modem_ready_out;
    logic clear_channel_out;
    logic energy_detect_out;
    logic carrier_sense_out;
    logic tx_ready_out;
    logic [31:0] prdata;
    logic pslverr;
  } dbio_state_t;

endpackage : dbio_pkg

// file: dbio_regs.sv
// APB register bank for receive status, pin polarity, signal strength, converter steps and spreading code.
// Assumes baseband core signals share pclk; transmit_enable_in arrives asynchronously from the MAC.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "dbio_cfg.svh"

module dbio_regs #(
  parameter int SFD_TIMEOUT_CYCLES = `DBIO_SFD_TIMEOUT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rx_signal_field,
  input wire logic rx_header_valid,
  input wire logic rx_mod_qpsk,
  input wire logic rx_sfd_search_start,
  input wire logic rx_sfd_found,
  output logic rx_acq_restart,
  input wire logic rx_packet_active,
  input wire logic tx_header_sent,
  input wire logic cca_raw,
  input wire logic energy_detect_raw,
  input wire logic carrier_sense_raw,
  input wire logic [5:0] rssi_sample,
  input wire logic rssi_sample_valid,
  input wire logic cal_up,
  input wire logic cal_down,
  output logic [7:0] converter_cal_level,
  input wire logic transmit_enable_in,
  output logic tx_enable,
  output logic spread_chip,
  output logic [15:0] spread_code,
  output logic rx_clk_out,
  output logic transmit_clock_out,
  output logic modem_ready_out,
  output logic clear_channel_out,
  output logic energy_detect_out,
  output logic carrier_sense_out,
  output logic tx_ready_out
);

  localparam logic [7:0] LINK_HALF = 8'(`DBIO_LINK_HALF_CYCLES);
  localparam logic [15:0] SFD_LIMIT = 16'(SFD_TIMEOUT_CYCLES - 1);

  dbio_pkg::dbio_state_t cur;
  dbio_pkg::dbio_state_t next_cur;

  logic [`DBIO_ADDR_W-1:0] addr;
  logic setup_phase;
  logic wr_access;
  logic [15:0] code_word;
  logic [3:0] last_chip;
  logic link_tick;
  logic [8:0] cal_sum;
  logic [7:0] rd_value;
  logic rd_hit;

  assign addr = paddr[`DBIO_ADDR_W-1:0];
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign code_word = {cur.spread_hi, cur.spread_lo};
  assign link_tick = (cur.link_div == LINK_HALF - 8'h01);

  // Index of the first chip sent; code sits right justified
  always_comb begin
    case (cur.code_len)
      dbio_pkg::DBIO_LEN_11: last_chip = 4'hA;
      dbio_pkg::DBIO_LEN_13: last_chip = 4'hC;
      dbio_pkg::DBIO_LEN_15: last_chip = 4'hE;
      dbio_pkg::DBIO_LEN_16: last_chip = 4'hF;
      default: last_chip = 4'hA;
    endcase
  end

  // Read mux; unmapped offsets answer zero with an error
  always_comb begin
    rd_value = 8'h00;
    rd_hit = 1'b1;
    case (addr)
      `DBIO_ADDR_RX_STATUS: rd_value = {cur.sf_mismatch, cur.sfd_timeout, cur.mod_qpsk, cur.cal_level[7:3]};
      `DBIO_ADDR_POLARITY: rd_value = cur.polarity;
      `DBIO_ADDR_RSSI: rd_value = {2'b00, cur.rssi};
      `DBIO_ADDR_CAL_POS: rd_value = cur.cal_pos;
      `DBIO_ADDR_CAL_NEG: rd_value = cur.cal_neg;
      `DBIO_ADDR_SPREAD_HI: rd_value = cur.spread_hi;
      `DBIO_ADDR_SPREAD_LO: rd_value = cur.spread_lo;
      `DBIO_ADDR_CODE_LEN: rd_value = {6'h00, cur.code_len};
      `DBIO_ADDR_SF_CMP_A: rd_value = cur.sf_cmp_a;
      `DBIO_ADDR_SF_CMP_B: rd_value = cur.sf_cmp_b;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_cur = cur;
    cal_sum = 9'h000;

    // Data registered in setup so the access phase needs no wait state
    if (setup_phase) begin
      next_cur.prdata = {24'h000000, rd_value};
      next_cur.pslverr = !rd_hit;
    end

    // Register writes; status and strength offsets have no write path
    if (wr_access) begin
      case (addr)
        `DBIO_ADDR_POLARITY: next_cur.polarity = pwdata[7:0];
        `DBIO_ADDR_CAL_POS: next_cur.cal_pos = pwdata[7:0];
        `DBIO_ADDR_CAL_NEG: next_cur.cal_neg = pwdata[7:0];
        `DBIO_ADDR_SPREAD_HI: next_cur.spread_hi = pwdata[7:0];
        `DBIO_ADDR_SPREAD_LO: next_cur.spread_lo = pwdata[7:0];
        `DBIO_ADDR_CODE_LEN: next_cur.code_len = dbio_pkg::dbio_code_len_t'(pwdata[1:0]);
        `DBIO_ADDR_SF_CMP_A: next_cur.sf_cmp_a = pwdata[7:0];
        `DBIO_ADDR_SF_CMP_B: next_cur.sf_cmp_b = pwdata[7:0];
        default: next_cur.pslverr = cur.pslverr;
      endcase
    end

    // Header outcome latched per packet
    if (rx_header_valid) begin
      next_cur.sf_mismatch = (rx_signal_field != cur.sf_cmp_a) && (rx_signal_field != cur.sf_cmp_b);
      next_cur.mod_qpsk = rx_mod_qpsk;
    end

    // SFD search timer; a timeout sends the receiver back to acquisition
    next_cur.acq_restart = 1'b0;
    if (rx_sfd_search_start) begin
      next_cur.sfd_searching = 1'b1;
      next_cur.sfd_timer = 16'h0000;
      next_cur.sfd_timeout = 1'b0;
    end else if (cur.sfd_searching) begin
      if (rx_sfd_found) begin
        next_cur.sfd_searching = 1'b0;
      end else if (cur.sfd_timer == SFD_LIMIT) begin
        next_cur.sfd_searching = 1'b0;
        next_cur.sfd_timeout = 1'b1;
        next_cur.acq_restart = 1'b1;
      end else begin
        next_cur.sfd_timer = cur.sfd_timer + 16'h0001;
      end
    end

    if (rssi_sample_valid) begin
      next_cur.rssi = rssi_sample;
    end

    // Reference loop saturates at both ends rather than wrapping
    if (cal_up) begin
      cal_sum = {1'b0, cur.cal_level} + {1'b0, cur.cal_pos};
      next_cur.cal_level = cal_sum[8] ? 8'hFF : cal_sum[7:0];
    end else if (cal_down) begin
      cal_sum = {1'b0, cur.cal_level} + {1'b0, cur.cal_neg};
      next_cur.cal_level = cal_sum[8] ? cal_sum[7:0] : 8'h00;
    end

    // Transmit-enable pin: two flops, then the programmed sense
    next_cur.txen_sync1 = transmit_enable_in;
    next_cur.txen_sync2 = cur.txen_sync1;
    next_cur.tx_enable = cur.txen_sync2 ^ cur.polarity[`DBIO_POL_TXEN];

    // Bit clock divided down from pclk
    if (link_tick) begin
      next_cur.link_div = 8'h00;
      next_cur.link_clk = !cur.link_clk;
    end else begin
      next_cur.link_div = cur.link_div + 8'h01;
    end

    // Chips leave MSB first on the falling bit-clock edge while enabled
    if (!cur.tx_enable) begin
      next_cur.chip_idx = last_chip;
      next_cur.chip = 1'b0;
    end else if (link_tick && cur.link_clk) begin
      next_cur.chip = code_word[cur.chip_idx];
      next_cur.chip_idx = (cur.chip_idx == 4'h0) ? last_chip : cur.chip_idx - 4'h1;
    end

    // Pin drivers with programmed phase and active level
    next_cur.rx_clk_out = cur.link_clk ^ cur.polarity[`DBIO_POL_RXCLK];
    next_cur.tx_clk_out = cur.link_clk ^ cur.polarity[`DBIO_POL_TX_CLOCK];
    next_cur.modem_ready_out = rx_packet_active ^ cur.polarity[`DBIO_POL_MDRDY];
    next_cur.clear_channel_out = cca_raw ^ !cur.polarity[`DBIO_POL_CCA];
    next_cur.energy_detect_out = energy_detect_raw ^ cur.polarity[`DBIO_POL_ENERGY];
    next_cur.carrier_sense_out = carrier_sense_raw ^ cur.polarity[`DBIO_POL_CARRIER];
    next_cur.tx_ready_out = tx_header_sent ^ cur.polarity[`DBIO_POL_TXRDY];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur.polarity <= `DBIO_RST_POLARITY;
      cur.cal_pos <= `DBIO_RST_CAL_POS;
      cur.cal_neg <= `DBIO_RST_CAL_NEG;
      cur.cal_level <= `DBIO_RST_CAL_LEVEL;
      cur.spread_hi <= `DBIO_RST_SPREAD_HI;
      cur.spread_lo <= `DBIO_RST_SPREAD_LO;
      cur.code_len <= dbio_pkg::DBIO_LEN_11;
      cur.sf_cmp_a <= `DBIO_RST_SF_CMP;
      cur.sf_cmp_b <= `DBIO_RST_SF_CMP;
      cur.rssi <= 6'h00;
      cur.sf_mismatch <= 1'b0;
      cur.sfd_timeout <= 1'b0;
      cur.mod_qpsk <= 1'b0;
      cur.sfd_timer <= 16'h0000;
      cur.sfd_searching <= 1'b0;
      cur.acq_restart <= 1'b0;
      cur.link_div <= 8'h00;
      cur.link_clk <= 1'b0;
      cur.chip_idx <= 4'hA;
      cur.chip <= 1'b0;
      cur.txen_sync1 <= 1'b0;
      cur.txen_sync2 <= 1'b0;
      cur.tx_enable <= 1'b0;
      cur.rx_clk_out <= 1'b0;
      cur.tx_clk_out <= 1'b0;
      // Inactive levels for the reset polarity setting
      cur.modem_ready_out <= 1'b0;
      cur.clear_channel_out <= 1'b1;
      cur.energy_detect_out <= 1'b0;
      cur.carrier_sense_out <= 1'b0;
      cur.tx_ready_out <= 1'b0;
      cur.prdata <= 32'h00000000;
      cur.pslverr <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign pready = 1'b1;
  assign prdata = cur.prdata;
  assign pslverr = cur.pslverr && psel && penable;
  assign rx_acq_restart = cur.acq_restart;
  assign converter_cal_level = cur.cal_level;
  assign tx_enable = cur.tx_enable;
  assign spread_chip = cur.chip;
  assign spread_code = code_word;
  assign rx_clk_out = cur.rx_clk_out;
  assign transmit_clock_out = cur.tx_clk_out;
  assign modem_ready_out = cur.modem_ready_out;
  assign clear_channel_out = cur.clear_channel_out;
  assign energy_detect_out = cur.energy_detect_out;
  assign carrier_sense_out = cur.carrier_sense_out;
  assign tx_ready_out = cur.tx_ready_out;

endmodule : dbio_regs

// file: dbio_regs_properties.sv
// Port checker for dbio_regs, bound below.
// Assumes APB writes at 0x24 set pin polarity.
`timescale 1ns/1ps
module dbio_regs_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic rx_packet_active,
  input wire logic tx_header_sent,
  input wire logic cca_raw,
  input wire logic energy_detect_raw,
  input wire logic carrier_sense_raw,
  input wire logic transmit_enable_in,
  input wire logic tx_enable,
  input wire logic [15:0] spread_code,
  input wire logic modem_ready_out,
  input wire logic clear_channel_out,
  input wire logic energy_detect_out,
  input wire logic carrier_sense_out,
  input wire logic tx_ready_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] pol;
  logic acc;
  assign acc = psel && penable;
  // Shadow copy, since polarity is not visible at the ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pol <= 8'h00;
    else if (acc && pwrite && paddr[7:0] == 8'h24) pol <= pwdata[7:0];
  end
  property p_mdrdy; modem_ready_out == ($past(rx_packet_active) ^ $past(pol[6])); endproperty
  a_mdrdy: assert property (p_mdrdy) else $error("modem ready level");
  property p_cca; clear_channel_out == ($past(cca_raw) ^ !$past(pol[5])); endproperty
  a_cca: assert property (p_cca) else $error("channel clear level");
  property p_energy; energy_detect_out == ($past(energy_detect_raw) ^ $past(pol[4])); endproperty
  a_energy: assert property (p_energy) else $error("energy detect level");
  property p_carrier; carrier_sense_out == ($past(carrier_sense_raw) ^ $past(pol[3])); endproperty
  a_carrier: assert property (p_carrier) else $error("carrier sense level");
  property p_txrdy; tx_ready_out == ($past(tx_header_sent) ^ $past(pol[2])); endproperty
  a_txrdy: assert property (p_txrdy) else $error("transmit ready level");
  property p_txen; ($past(pol[1], 4) == pol[1]) |-> tx_enable == ($past(transmit_enable_in, 3) ^ pol[1]); endproperty
  a_txen: assert property (p_txen) else $error("transmit enable sense");
  property p_rssi; acc && paddr[7:0] == 8'h28 |-> prdata[31:6] == 26'h0; endproperty
  a_rssi: assert property (p_rssi) else $error("strength upper bits");
  property p_code; $past(acc && pwrite && paddr[7:0] == 8'h34) |-> spread_code[15:8] == $past(pwdata[7:0]); endproperty
  a_code: assert property (p_code) else $error("upper code byte");
  c_txen: cover property (tx_enable);
  c_pol: cover property (pol == 8'hFF);
  c_code: cover property (acc && pwrite && paddr[7:0] == 8'h34);
endmodule : dbio_regs_properties

bind dbio_regs dbio_regs_properties dbio_regs_properties_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .rx_packet_active, .tx_header_sent, .cca_raw, .energy_detect_raw,
  .carrier_sense_raw, .transmit_enable_in, .tx_enable, .spread_code, .modem_ready_out,
  .clear_channel_out, .energy_detect_out, .carrier_sense_out, .tx_ready_out);

// file: dbio_mac_model.sv
// Controller model driving the transmit enable pin.
// Assumes active_low mirrors the polarity setting.
`timescale 1ns/1ps
module dbio_mac_model #(
  parameter int LAG = 2
) (
  input wire logic pclk,
  input wire logic active_low,
  input wire logic req,
  output logic transmit_enable_in
);
  logic [7:0] hist = 8'h00;
  // Slow answer: request shows LAG cycles late
  always_ff @(posedge pclk) hist <= {hist[6:0], req};
  assign transmit_enable_in = hist[LAG-1] ^ active_low;
endmodule : dbio_mac_model

// file: dbio_regs_test.sv
// Bench for dbio_regs: APB tasks, pin and status checks.
// Assumes zero-wait APB and a 16-cycle SFD timeout.
`timescale 1ns/1ps
module dbio_regs_test;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, req = '0, low = '0, qp = '0, acc;
  logic [31:0] paddr = '0, pwdata = '0, q;
  logic [7:0] sf = '0, p;
  logic [15:0] sh = '0;
  logic [5:0] ev = '0, rssi = '0;
  logic [4:0] raw = '0;
  wire [31:0] prdata;
  wire [15:0] code;
  wire [7:0] lvl;
  wire [4:0] pin;
  wire pready, pslverr, racq, tx_en, chip, rxc, txc, txe;
  int failures = 0, n_compared = 0, nr;
  logic [7:0] pols [3] = '{8'h00, 8'hFF, 8'h55};
  logic [4:0] raws [3] = '{5'h00, 5'h1F, 5'h0A};
  logic [8:0] hdr [3] = '{9'h10A, 9'h00B, 9'h13C};
  logic [1:0] hexp [3] = '{2'b01, 2'b10, 2'b01};
  initial forever #4 pclk = ~pclk;
  dbio_regs #(.SFD_TIMEOUT_CYCLES(16)) dbio_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_signal_field(sf), .rx_header_valid(ev[0]), .rx_mod_qpsk(qp),
    .rx_sfd_search_start(ev[1]), .rx_sfd_found(ev[2]), .rx_acq_restart(racq), .rx_packet_active(raw[4]),
    .tx_header_sent(raw[0]), .cca_raw(raw[3]), .energy_detect_raw(raw[2]), .carrier_sense_raw(raw[1]),
    .rssi_sample(rssi), .rssi_sample_valid(ev[3]), .cal_up(ev[4]), .cal_down(ev[5]),
    .converter_cal_level(lvl), .transmit_enable_in(txe), .tx_enable(tx_en), .spread_chip(chip),
    .spread_code(code), .rx_clk_out(rxc), .transmit_clock_out(txc), .modem_ready_out(pin[4]),
    .clear_channel_out(pin[3]), .energy_detect_out(pin[2]), .carrier_sense_out(pin[1]), .tx_ready_out(pin[0]));
  dbio_mac_model dbio_mac_model_inst (.pclk(pclk), .active_low(low), .req(req), .transmit_enable_in(txe));
  task automatic summarize;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h00, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    acc = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      summarize();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(q & m, e);
  endtask : rd
  // Extra edge so checks never race the update
  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= '0;
    @(posedge pclk);
  endtask : pulse
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h2C, 32'hFF, 32'h01);
    rd(8'h30, 32'hFF, 32'hFF);
    rd(8'h34, 32'hFF, 32'h05);
    rd(8'h04, 32'hFFFFFFFF, 32'h0);
    cmp(32'(acc), 32'h1);
    foreach (pols[i]) begin
      p = pols[i];
      apb(1'b1, 8'h24, {24'h0, p});
      rd(8'h24, 32'hFF, {24'h0, p});
      foreach (raws[j]) begin
        raw <= raws[j];
        repeat (3) @(posedge pclk);
        cmp(32'(pin), 32'(raws[j] ^ {p[6], ~p[5], p[4], p[3], p[2]}));
        cmp(32'(rxc ^ txc), 32'(p[7] ^ p[0]));
      end
    end
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 8'h24, 32'(k * 2));
      low <= k[0];
      req <= 1'b1;
      repeat (8) @(posedge pclk);
      cmp(32'(tx_en), 32'h1);
      req <= 1'b0;
      repeat (8) @(posedge pclk);
      cmp(32'({tx_en, chip}), 32'h0);
    end
    apb(1'b1, 8'hAC, 32'h3C);
    foreach (hdr[i]) begin
      sf <= hdr[i][7:0];
      qp <= hdr[i][8];
      pulse(0);
      rd(8'h20, 32'hA0, {24'h0, hexp[i][1], 1'b0, hexp[i][0], 5'h0});
    end
    pulse(1);
    nr = 0;
    repeat (24) begin
      @(posedge pclk);
      if (racq === 1'b1) nr++;
    end
    cmp(32'(nr), 32'h1);
    rd(8'h20, 32'h40, 32'h40);
    pulse(1);
    pulse(2);
    repeat (24) @(posedge pclk);
    rd(8'h20, 32'h40, 32'h0);
    rssi <= 6'h3F;
    pulse(3);
    apb(1'b1, 8'h28, 32'h0);
    rd(8'h28, 32'hFFFFFFFF, 32'h3F);
    rssi <= 6'h00;
    pulse(3);
    rd(8'h28, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, 8'h20, 32'hFF);
    rd(8'h20, 32'hFF, 32'h30);
    cmp(32'(lvl), 32'h80);
    apb(1'b1, 8'h2C, 32'h10);
    pulse(4);
    cmp(32'(lvl), 32'h90);
    rd(8'h20, 32'h1F, 32'h12);
    apb(1'b1, 8'h30, 32'(256 - 32));
    pulse(5);
    cmp(32'(lvl), 32'h70);
    apb(1'b1, 8'h34, 32'h1F);
    apb(1'b1, 8'h38, 32'h35);
    @(posedge pclk);
    cmp(32'(code), 32'h1F35);
    apb(1'b1, 8'h50, 32'h1);
    rd(8'h50, 32'h3, 32'h1);
    // Length 13 stream; pin still active low from the sense test
    req <= 1'b1;
    nr = 0;
    while (chip !== 1'b1 && nr < 60) begin
      @(posedge pclk);
      nr++;
    end
    if (nr >= 60) begin
      failures++;
      summarize();
    end
    // First chip seen; one chip per 14 pclk bit period
    sh = 16'h0001;
    repeat (15) begin
      repeat (14) @(posedge pclk);
      sh = {sh[14:0], chip};
    end
    cmp(32'(sh), 32'hF9AF);
    summarize();
  end
endmodule : dbio_regs_test
